/* File: dtc_phase.sv */
// module: machine cycle divider and count pin falling edge detection
`timescale 1ns/10ps
`default_nettype none
module dtc_phase (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_a_i,
  input wire logic pin_b_i,
  dtc_tick_if.src tk
);
  typedef struct packed {
    logic [3:0] phase;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] smp;
    logic [1:0] prev;
    logic [1:0] hit;
    logic tick;
  } dtc_ph_t;
  dtc_ph_t st_r;
  dtc_ph_t st_nxt;

  // divide by 12; sample once per cycle and compare with the last sample
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {pin_b_i, pin_a_i};
    st_nxt.s2 = st_r.s1;
    st_nxt.tick = 1'b0;
    st_nxt.hit = 2'b00;
    st_nxt.phase = (st_r.phase == dtc_pkg::MCYC_LAST) ? 4'h0 : st_r.phase + 4'h1;
    if (st_r.phase == dtc_pkg::SAMPLE_PHASE) begin
      st_nxt.smp = st_r.s2;
      st_nxt.prev = st_r.smp;
    end
    if (st_r.phase == dtc_pkg::MCYC_LAST) begin
      st_nxt.tick = 1'b1;
      st_nxt.hit = st_r.prev & ~st_r.smp;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tk.mcyc = st_r.tick;
  assign tk.edge_a = st_r.hit[0];
  assign tk.edge_b = st_r.hit[1];
endmodule
`default_nettype wire

/* File: dtc_pin_model.sv */
// partner: drives the count and gate pins of the dual timer
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_model (
  input wire logic clk_i,
  output logic cnt_a_o,
  output logic cnt_b_o,
  output logic irq_a_o,
  output logic irq_b_o
);
  // pins idle high
  initial begin
    cnt_a_o = 1'b1;
    cnt_b_o = 1'b1;
    irq_a_o = 1'b1;
    irq_b_o = 1'b1;
  end
  // n falling edges, low held hold clocks, high held hold+1 clocks between pulses
  task automatic pulse_a(input int n, input int hold);
    repeat (n) begin
      @(posedge clk_i) cnt_a_o <= 1'b0;
      repeat (hold) @(posedge clk_i);
      cnt_a_o <= 1'b1;
      repeat (hold) @(posedge clk_i);
    end
  endtask
  task automatic gate_a(input logic v);
    @(posedge clk_i) irq_a_o <= v;
  endtask
  task automatic gate_b(input logic v);
    @(posedge clk_i) irq_b_o <= v;
  endtask
endmodule
`default_nettype wire

/* File: dtc_pkg.sv */
// package: register map, field positions and timing constants of the dual timer
package dtc_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned OSC_PER_MCYC = 12;
  localparam logic [3:0] MCYC_LAST = 4'(OSC_PER_MCYC - 1);
  localparam logic [3:0] SAMPLE_PHASE = 4'h9;
  localparam logic [7:0] OFF_CTRL = 8'h88;
  localparam logic [7:0] OFF_MODE = 8'h89;
  localparam logic [7:0] OFF_TL_A = 8'h8A;
  localparam logic [7:0] OFF_TL_B = 8'h8B;
  localparam logic [7:0] OFF_TH_A = 8'h8C;
  localparam logic [7:0] OFF_TH_B = 8'h8D;
  localparam logic [7:0] OFF_ACK = 8'h8E;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h90;
  localparam logic [7:0] OFF_IRQ_EN = 8'h91;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h92;
  localparam int BIT_OVF_B = 7;
  localparam int BIT_RUN_B = 6;
  localparam int BIT_OVF_A = 5;
  localparam int BIT_RUN_A = 4;
  localparam int BIT_EDGE_B = 3;
  localparam int BIT_TYPE_B = 2;
  localparam int BIT_EDGE_A = 1;
  localparam int BIT_TYPE_A = 0;
  localparam int MODE_GATE = 3;
  localparam int MODE_CNT = 2;
  localparam int MODE_UPPER = 1;
  localparam int MODE_LOWER = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [4:0] PRESCALE_MAX = 5'h1F;
  typedef enum logic [1:0] {DTC_M_PRE13, DTC_M_CAS16, DTC_M_RELOAD8, DTC_M_SPLIT} dtc_mode_t;
endpackage

/* File: dtc_tick_if.sv */
// interface: per-machine-cycle ticks and counted pin edges shared between modules
`timescale 1ns/10ps
`default_nettype none
interface dtc_tick_if;
  logic mcyc;
  logic edge_a;
  logic edge_b;
  modport src(output mcyc, output edge_a, output edge_b);
  modport dst(input mcyc, input edge_a, input edge_b);
endinterface
`default_nettype wire

/* File: dtc_top.sv */
// module: two timer/event counters with control, mode and interrupt registers
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module dtc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic count_pin_a_i,
  input wire logic count_pin_b_i,
  input wire logic ext_irq_pin_a_i,
  input wire logic ext_irq_pin_b_i,
  output logic ext_irq_a_o,
  output logic ext_irq_b_o,
  output logic ovf_irq_a_o,
  output logic ovf_irq_b_o,
  output logic baud_pulse_o,
  output logic irq_o
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] tl_a;
    logic [7:0] th_a;
    logic [7:0] tl_b;
    logic [7:0] th_b;
    logic [3:0] ist;
    logic [3:0] ien;
    logic [1:0] gs1;
    logic [1:0] gs2;
    logic [1:0] gprev;
    logic baud;
    logic ack;
    logic [31:0] rdat;
  } dtc_st_t;
  dtc_st_t st_r;
  dtc_st_t st_nxt;
  dtc_tick_if tk ();

  dtc_phase u_phase (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_a_i(count_pin_a_i),
    .pin_b_i(count_pin_b_i),
    .tk(tk)
  );

  // one step of an 8-bit counter, returning carry out in bit 8
  function automatic logic [8:0] dtc_inc8(input logic [7:0] v, input logic en);
    dtc_inc8 = {1'b0, v} + {8'h00, en};
  endfunction

  logic wr;
  logic rd;
  logic [1:0] gpin;
  logic [1:0] run_ok;
  logic [1:0] src;
  logic [8:0] sl;
  logic [8:0] sh;
  logic [8:0] bl;
  logic [8:0] bh;
  logic ovf_a;
  logic ovf_b;
  logic ovf_th_a;
  logic split;
  logic [1:0] mode_a;
  logic [1:0] mode_b;
  logic [7:0] m;

  always_comb begin
    wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~st_r.ack;
    rd = wb_cyc_i & wb_stb_i & ~st_r.ack;
  end

  // gating, function select and count sources
  always_comb begin
    m = st_r.mode;
    mode_a = {m[dtc_pkg::MODE_UPPER], m[dtc_pkg::MODE_LOWER]};
    mode_b = {m[4 + dtc_pkg::MODE_UPPER], m[4 + dtc_pkg::MODE_LOWER]};
    split = (mode_a == 2'(dtc_pkg::DTC_M_SPLIT));
    gpin = st_r.gs2;
    run_ok[0] = st_r.ctrl[dtc_pkg::BIT_RUN_A] & (~m[dtc_pkg::MODE_GATE] | gpin[0]);
    run_ok[1] = st_r.ctrl[dtc_pkg::BIT_RUN_B] & (~m[4 + dtc_pkg::MODE_GATE] | gpin[1]);
    src[0] = m[dtc_pkg::MODE_CNT] ? tk.edge_a : tk.mcyc;
    src[1] = m[4 + dtc_pkg::MODE_CNT] ? tk.edge_b : tk.mcyc;
  end

  // counting datapath for both timers
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.baud = 1'b0;
    st_nxt.gs1 = {ext_irq_pin_b_i, ext_irq_pin_a_i};
    st_nxt.gs2 = st_r.gs1;
    st_nxt.gprev = st_r.gs2;
    ovf_a = 1'b0;
    ovf_b = 1'b0;
    ovf_th_a = 1'b0;
    sl = dtc_inc8(st_r.tl_a, run_ok[0] & src[0]);
    sh = '0;
    bl = '0;
    bh = '0;
    // timer a
    case (mode_a)
      2'(dtc_pkg::DTC_M_PRE13): begin
        sl = dtc_inc8({3'b000, st_r.tl_a[4:0]}, run_ok[0] & src[0]);
        sh = dtc_inc8(st_r.th_a, (run_ok[0] & src[0]) && st_r.tl_a[4:0] == dtc_pkg::PRESCALE_MAX);
        st_nxt.tl_a = {st_r.tl_a[7:5], sl[4:0]};
        st_nxt.th_a = sh[7:0];
        ovf_a = sh[8];
      end
      2'(dtc_pkg::DTC_M_CAS16): begin
        sh = dtc_inc8(st_r.th_a, sl[8]);
        st_nxt.tl_a = sl[7:0];
        st_nxt.th_a = sh[7:0];
        ovf_a = sh[8];
      end
      2'(dtc_pkg::DTC_M_RELOAD8): begin
        st_nxt.tl_a = sl[8] ? st_r.th_a : sl[7:0];
        ovf_a = sl[8];
      end
      default: begin
        st_nxt.tl_a = sl[7:0];
        ovf_a = sl[8];
        sh = dtc_inc8(st_r.th_a, st_r.ctrl[dtc_pkg::BIT_RUN_B] & tk.mcyc);
        st_nxt.th_a = sh[7:0];
        ovf_th_a = sh[8];
      end
    endcase
    // timer b
    bl = dtc_inc8(st_r.tl_b, run_ok[1] & src[1]);
    case (mode_b)
      2'(dtc_pkg::DTC_M_PRE13): begin
        bl = dtc_inc8({3'b000, st_r.tl_b[4:0]}, run_ok[1] & src[1]);
        bh = dtc_inc8(st_r.th_b, (run_ok[1] & src[1]) && st_r.tl_b[4:0] == dtc_pkg::PRESCALE_MAX);
        st_nxt.tl_b = {st_r.tl_b[7:5], bl[4:0]};
        st_nxt.th_b = bh[7:0];
        ovf_b = bh[8];
      end
      2'(dtc_pkg::DTC_M_CAS16): begin
        bh = dtc_inc8(st_r.th_b, bl[8]);
        st_nxt.tl_b = bl[7:0];
        st_nxt.th_b = bh[7:0];
        ovf_b = bh[8];
      end
      2'(dtc_pkg::DTC_M_RELOAD8): begin
        st_nxt.tl_b = bl[8] ? st_r.th_b : bl[7:0];
        ovf_b = bl[8];
      end
      default: begin
        ovf_b = 1'b0;
      end
    endcase
    st_nxt.baud = ovf_b;
    // overflow flags; in split mode a's high byte owns flag b
    if (wr && wb_adr_i == dtc_pkg::OFF_ACK) begin
      if (wb_dat_i[0]) st_nxt.ctrl[dtc_pkg::BIT_OVF_A] = 1'b0;
      if (wb_dat_i[1]) st_nxt.ctrl[dtc_pkg::BIT_OVF_B] = 1'b0;
      if (wb_dat_i[2]) st_nxt.ctrl[dtc_pkg::BIT_EDGE_A] = 1'b0;
      if (wb_dat_i[3]) st_nxt.ctrl[dtc_pkg::BIT_EDGE_B] = 1'b0;
    end
    if (wr && wb_adr_i == dtc_pkg::OFF_CTRL) begin
      st_nxt.ctrl[dtc_pkg::BIT_RUN_B] = wb_dat_i[dtc_pkg::BIT_RUN_B];
      st_nxt.ctrl[dtc_pkg::BIT_RUN_A] = wb_dat_i[dtc_pkg::BIT_RUN_A];
      st_nxt.ctrl[dtc_pkg::BIT_TYPE_B] = wb_dat_i[dtc_pkg::BIT_TYPE_B];
      st_nxt.ctrl[dtc_pkg::BIT_TYPE_A] = wb_dat_i[dtc_pkg::BIT_TYPE_A];
    end
    if (ovf_a) st_nxt.ctrl[dtc_pkg::BIT_OVF_A] = 1'b1;
    if (split ? ovf_th_a : ovf_b) st_nxt.ctrl[dtc_pkg::BIT_OVF_B] = 1'b1;
    // external interrupt flags: edge sets, level mode follows inverted pin
    for (int i = 0; i < 2; i++) begin
      if (st_r.ctrl[dtc_pkg::BIT_TYPE_A + 2 * i]) begin
        if (st_r.gprev[i] & ~st_r.gs2[i]) st_nxt.ctrl[dtc_pkg::BIT_EDGE_A + 2 * i] = 1'b1;
      end else begin
        st_nxt.ctrl[dtc_pkg::BIT_EDGE_A + 2 * i] = ~st_r.gs2[i];
      end
    end
    // sticky status set by overflow pulses and by edge flag rising; set beats clear
    if (wr && wb_adr_i == dtc_pkg::OFF_IRQ_CLR) st_nxt.ist = st_r.ist & ~wb_dat_i[3:0];
    if (ovf_a) st_nxt.ist[0] = 1'b1;
    if (split ? ovf_th_a : ovf_b) st_nxt.ist[1] = 1'b1;
    if (st_nxt.ctrl[dtc_pkg::BIT_EDGE_A] & ~st_r.ctrl[dtc_pkg::BIT_EDGE_A]) st_nxt.ist[2] = 1'b1;
    if (st_nxt.ctrl[dtc_pkg::BIT_EDGE_B] & ~st_r.ctrl[dtc_pkg::BIT_EDGE_B]) st_nxt.ist[3] = 1'b1;
    if (wr && wb_adr_i == dtc_pkg::OFF_IRQ_EN) st_nxt.ien = wb_dat_i[3:0];
    if (wr && wb_adr_i == dtc_pkg::OFF_MODE) st_nxt.mode = wb_dat_i[7:0];
    // software loads of count bytes override counting
    if (wr && wb_adr_i == dtc_pkg::OFF_TL_A) st_nxt.tl_a = wb_dat_i[7:0];
    if (wr && wb_adr_i == dtc_pkg::OFF_TH_A) st_nxt.th_a = wb_dat_i[7:0];
    if (wr && wb_adr_i == dtc_pkg::OFF_TL_B) st_nxt.tl_b = wb_dat_i[7:0];
    if (wr && wb_adr_i == dtc_pkg::OFF_TH_B) st_nxt.th_b = wb_dat_i[7:0];
    // read mux, registered with the ack
    st_nxt.ack = rd;
    st_nxt.rdat = '0;
    case (wb_adr_i)
      dtc_pkg::OFF_CTRL: st_nxt.rdat = {24'h000000, st_r.ctrl};
      dtc_pkg::OFF_MODE: st_nxt.rdat = {24'h000000, st_r.mode};
      dtc_pkg::OFF_TL_A: st_nxt.rdat = {24'h000000, st_r.tl_a};
      dtc_pkg::OFF_TH_A: st_nxt.rdat = {24'h000000, st_r.th_a};
      dtc_pkg::OFF_TL_B: st_nxt.rdat = {24'h000000, st_r.tl_b};
      dtc_pkg::OFF_TH_B: st_nxt.rdat = {24'h000000, st_r.th_b};
      dtc_pkg::OFF_IRQ_STAT: st_nxt.rdat = {28'h0000000, st_r.ist};
      dtc_pkg::OFF_IRQ_EN: st_nxt.rdat = {28'h0000000, st_r.ien};
      default: st_nxt.rdat = '0;
    endcase
  end

  // state register; reset clears mode and control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.ctrl <= dtc_pkg::CTRL_RESET;
      st_r.mode <= dtc_pkg::MODE_RESET;
      // gate pins idle high; start high so no false edge or level follows reset
      st_r.gs1 <= 2'h3;
      st_r.gs2 <= 2'h3;
      st_r.gprev <= 2'h3;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
  assign ext_irq_a_o = st_r.ctrl[dtc_pkg::BIT_EDGE_A];
  assign ext_irq_b_o = st_r.ctrl[dtc_pkg::BIT_EDGE_B];
  assign ovf_irq_a_o = st_r.ctrl[dtc_pkg::BIT_OVF_A];
  assign ovf_irq_b_o = st_r.ctrl[dtc_pkg::BIT_OVF_B];
  assign baud_pulse_o = st_r.baud;
  assign irq_o = |(st_r.ist & st_r.ien);
endmodule
`default_nettype wire

/* File: dtc_top_properties.sv */
// checker: port-level properties of the dual timer block
`timescale 1ns/10ps
`default_nettype none
module dtc_top_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic count_pin_a_i,
  input wire logic count_pin_b_i,
  input wire logic ext_irq_pin_a_i,
  input wire logic ext_irq_pin_b_i,
  input wire logic ext_irq_a_o,
  input wire logic ext_irq_b_o,
  input wire logic ovf_irq_a_o,
  input wire logic ovf_irq_b_o,
  input wire logic baud_pulse_o,
  input wire logic irq_o
);
  logic [5:0] low_a_r;
  logic ackw;
  logic clr_a;
  logic clr_b;
  // write strobes into the overflow acknowledge register
  assign ackw = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & (wb_adr_i == dtc_pkg::OFF_ACK);
  assign clr_a = ackw & wb_dat_i[0];
  assign clr_b = ackw & wb_dat_i[1];
  // recent low samples of gate pin a
  always_ff @(posedge clk_i) begin
    if (rst_i) low_a_r <= 6'h00;
    else low_a_r <= {low_a_r[4:0], ~ext_irq_pin_a_i};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("stray ack");
  a_data_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data");
  a_reset_quiet: assert property ($fell(rst_i) |-> !(irq_o | ovf_irq_a_o | ovf_irq_b_o))
    else $error("flags set after reset");
  a_baud_spacing: assert property (baud_pulse_o |=> !baud_pulse_o [*8])
    else $error("baud pulses too close");
  a_ovf_a_clear: assert property ($fell(ovf_irq_a_o) |->
    clr_a || $past(clr_a) || $past(clr_a, 2)) else $error("overflow a cleared without ack");
  a_ovf_b_clear: assert property ($fell(ovf_irq_b_o) |->
    clr_b || $past(clr_b) || $past(clr_b, 2)) else $error("overflow b cleared without ack");
  a_edge_cause: assert property ($rose(ext_irq_a_o) |-> |low_a_r)
    else $error("edge flag without low pin");
  // main scenarios reached
  cover property ($rose(ovf_irq_a_o));
  cover property (baud_pulse_o);
  cover property ($rose(irq_o));
endmodule
`default_nettype wire

/* File: tb_top.sv */
// testbench: registers, modes, pins and interrupts of the dual timer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, ack, eia, eib, ova, ovb, baud, irq, cpa, cpb, ipa, ipb;
  logic [7:0] adr, q, x;
  logic [31:0] dat, dout;
  int fails, num_checks, nbaud;
  dtc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
    .count_pin_a_i(cpa), .count_pin_b_i(cpb), .ext_irq_pin_a_i(ipa), .ext_irq_pin_b_i(ipb),
    .ext_irq_a_o(eia), .ext_irq_b_o(eib), .ovf_irq_a_o(ova), .ovf_irq_b_o(ovb),
    .baud_pulse_o(baud), .irq_o(irq));
  dtc_pin_model pins (.clk_i(clk_i), .cnt_a_o(cpa), .cnt_b_o(cpb), .irq_a_o(ipa), .irq_b_o(ipb));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (baud === 1'b1) nbaud++;
  // one classic bus cycle, then one idle cycle
  task automatic wb(input logic [7:0] a, input logic [7:0] d, input logic w = 1'b1);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, 24'h0, d};
    // wait for the answer however long it takes; the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dout[7:0];
    {cyc, stb} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic chkr(input string s, input logic [7:0] lo, input logic [7:0] hi,
    input logic [7:0] g);
    num_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      fails++;
      $display("mismatch %s expected %h..%h seen %h", s, lo, hi, g);
    end
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    chkr(s, e, e, g);
  endtask
  task automatic print_verdict;
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic s_regs;
    wb(dtc_pkg::OFF_CTRL, 0, 0);
    chk("ctrl", dtc_pkg::CTRL_RESET, q);
    wb(dtc_pkg::OFF_MODE, 0, 0);
    chk("mode", dtc_pkg::MODE_RESET, q);
    wb(8'h80, 8'h5A);
    wb(8'h80, 0, 0);
    chk("unmapped", 8'h00, q);
    wb(dtc_pkg::OFF_MODE, 8'hA5);
    wb(dtc_pkg::OFF_MODE, 0, 0);
    chk("mode", 8'hA5, q);
    wb(dtc_pkg::OFF_CTRL, 8'hFF);
    wb(dtc_pkg::OFF_CTRL, 0, 0);
    chk("ctrl", 8'h55, q);
    wb(dtc_pkg::OFF_CTRL, 8'h00);
  endtask
  task automatic s_timer(input logic [7:0] m, input int k, input logic [7:0] a,
    input logic [7:0] lo, input logic [7:0] hi);
    wb(dtc_pkg::OFF_MODE, m);
    wb(dtc_pkg::OFF_TL_A, 8'h00);
    wb(dtc_pkg::OFF_TH_A, 8'h00);
    wb(dtc_pkg::OFF_CTRL, 8'h10);
    repeat (k) @(posedge clk_i);
    wb(dtc_pkg::OFF_CTRL, 8'h00);
    wb(a, 0, 0);
    chkr("count", lo, hi, q);
  endtask
  task automatic s_reload_irq;
    wb(dtc_pkg::OFF_MODE, 8'h02);
    wb(dtc_pkg::OFF_TH_A, 8'hFC);
    wb(dtc_pkg::OFF_TL_A, 8'hFC);
    wb(dtc_pkg::OFF_IRQ_EN, 8'h01);
    wb(dtc_pkg::OFF_CTRL, 8'h10);
    repeat (96) @(posedge clk_i);
    wb(dtc_pkg::OFF_CTRL, 8'h00);
    chk("ovf_a", 8'h01, {7'h0, ova});
    chk("irq", 8'h01, {7'h0, irq});
    wb(dtc_pkg::OFF_TL_A, 0, 0);
    chkr("tl_a", 8'hFC, 8'hFF, q);
    wb(dtc_pkg::OFF_IRQ_EN, 8'h00);
    chk("irq", 8'h00, {7'h0, irq});
    wb(dtc_pkg::OFF_ACK, 8'h01);
    chk("ovf_a", 8'h00, {7'h0, ova});
    wb(dtc_pkg::OFF_IRQ_STAT, 0, 0);
    chk("stat", 8'h01, q);
    wb(dtc_pkg::OFF_IRQ_CLR, 8'h01);
    wb(dtc_pkg::OFF_IRQ_STAT, 0, 0);
    chk("stat", 8'h00, q);
  endtask
  task automatic s_b(input logic [7:0] m, input logic [7:0] f);
    wb(dtc_pkg::OFF_MODE, m);
    wb(dtc_pkg::OFF_TH_A, 8'h00);
    wb(dtc_pkg::OFF_TH_B, 8'hFE);
    wb(dtc_pkg::OFF_TL_B, 8'hFE);
    nbaud = 0;
    wb(dtc_pkg::OFF_CTRL, 8'h40);
    repeat (117) @(posedge clk_i);
    wb(dtc_pkg::OFF_CTRL, 8'h00);
    chk("ovf_b", f, {7'h0, ovb});
    chkr("baud", 8'h04, 8'h06, 8'(nbaud));
    wb(dtc_pkg::OFF_ACK, 8'h02);
    chk("ovf_b", 8'h00, {7'h0, ovb});
    wb(dtc_pkg::OFF_TH_A, 0, 0);
    chkr("th_a", m[0] ? 8'h0A : 8'h00, m[0] ? 8'h0B : 8'h00, q);
  endtask
  task automatic s_pins;
    wb(dtc_pkg::OFF_MODE, 8'h35);
    wb(dtc_pkg::OFF_TL_A, 8'h00);
    wb(dtc_pkg::OFF_TL_B, 0, 0);
    x = q;
    wb(dtc_pkg::OFF_CTRL, 8'h50);
    pins.pulse_a(5, 12);
    pins.pulse_a(2, 40);
    repeat (40) @(posedge clk_i);
    wb(dtc_pkg::OFF_TL_A, 0, 0);
    chk("tl_a", 8'h07, q);
    wb(dtc_pkg::OFF_TL_B, 0, 0);
    chk("tl_b", x, q);
    wb(dtc_pkg::OFF_MODE, 8'h09);
    wb(dtc_pkg::OFF_CTRL, 8'h11);
    pins.gate_a(1'b0);
    repeat (6) @(posedge clk_i);
    chk("edge_a", 8'h01, {7'h0, eia});
    wb(dtc_pkg::OFF_TL_A, 8'h00);
    repeat (117) @(posedge clk_i);
    wb(dtc_pkg::OFF_TL_A, 0, 0);
    chk("tl_a", 8'h00, q);
    wb(dtc_pkg::OFF_ACK, 8'h04);
    chk("edge_a", 8'h00, {7'h0, eia});
    pins.gate_a(1'b1);
    wb(dtc_pkg::OFF_TL_A, 8'h00);
    repeat (117) @(posedge clk_i);
    wb(dtc_pkg::OFF_TL_A, 0, 0);
    chkr("tl_a", 8'h09, 8'h0B, q);
    wb(dtc_pkg::OFF_CTRL, 8'h00);
    pins.gate_a(1'b0);
    repeat (6) @(posedge clk_i);
    chk("level_a", 8'h01, {7'h0, eia});
    // low level on gate pin b shows on its flag too
    pins.gate_b(1'b0);
    repeat (6) @(posedge clk_i);
    chk("level_b", 8'h01, {7'h0, eib});
    // sticky status: overflow b from the reload run, both edge flags
    wb(dtc_pkg::OFF_IRQ_STAT, 0, 0);
    chk("stat", 8'h0E, q);
  endtask
  initial begin
    {rst_i, cyc, stb, we, adr, dat, fails, num_checks, nbaud} = '0;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    s_regs();
    s_timer(8'h01, 285, dtc_pkg::OFF_TL_A, 8'h17, 8'h19);
    s_timer(8'h00, 765, dtc_pkg::OFF_TH_A, 8'h01, 8'h02);
    s_reload_irq();
    s_b(8'h20, 8'h01);
    s_b(8'h23, 8'h00);
    s_pins();
    print_verdict();
  end
  initial begin
    #1000000;
    fails++;
    print_verdict();
  end
endmodule
bind dtc_top dtc_top_properties u_prop (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .count_pin_a_i, .count_pin_b_i,
  .ext_irq_pin_a_i, .ext_irq_pin_b_i, .ext_irq_a_o, .ext_irq_b_o, .ovf_irq_a_o,
  .ovf_irq_b_o, .baud_pulse_o, .irq_o);
`default_nettype wire
